// file: logic/uic_top.sv
// Added by the designer: the APB slave port and the placing of the registers.
`default_nettype none
module uic_top #(
    parameter int FILTER_CYC = uic_pkg::COS_FILTER_CYC
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cts_pin,
    output logic rts_n,
    output logic irq,
    output logic [7:0] irq_vector,
    output logic [15:0] baud_preload,
    input wire logic rx_ready_in,
    input wire logic fifo_full_in,
    input wire logic delta_break_in,
    input wire logic tx_shift_take,
    output logic tx_char_valid,
    output logic [7:0] tx_char
);
    logic [7:0] mask;
    logic [7:0] isr;
    logic [7:0] mode1;
    logic [7:0] aux;
    logic [7:0] ctrl;
    logic ipcr_cos;
    logic rts_bit;
    logic tx_ready;
    logic cts_level;
    logic cos_pulse;

    // Address match, shared by every decode below
    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = a == r;
    endfunction

    // Bus phases: data is set up in the setup cycle, effects at access end
    wire setup = psel && !penable;
    wire acc = psel && penable && pready;
    wire wr = acc && pwrite;
    wire rd = acc && !pwrite;

    // Register decode
    wire hit_mask = hit(paddr, uic_pkg::ADDR_MASK);
    wire hit_isr = hit(paddr, uic_pkg::ADDR_STATUS);
    wire hit_bhi = hit(paddr, uic_pkg::ADDR_BAUD_HI);
    wire hit_blo = hit(paddr, uic_pkg::ADDR_BAUD_LO);
    wire hit_vec = hit(paddr, uic_pkg::ADDR_VECTOR);
    wire hit_uip = hit(paddr, uic_pkg::ADDR_IN_LEVEL);
    wire hit_ipcr = hit(paddr, uic_pkg::ADDR_IN_CHANGE);
    wire hit_set = hit(paddr, uic_pkg::ADDR_OUT_SET);
    wire hit_clr = hit(paddr, uic_pkg::ADDR_OUT_CLEAR);
    wire hit_mr1 = hit(paddr, uic_pkg::ADDR_MODE1);
    wire hit_aux = hit(paddr, uic_pkg::ADDR_AUX);
    wire hit_txd = hit(paddr, uic_pkg::ADDR_TX_DATA);
    wire hit_ctl = hit(paddr, uic_pkg::ADDR_TX_CTRL);
    wire mapped = hit_mask || hit_isr || hit_bhi || hit_blo || hit_vec ||
        hit_uip || hit_ipcr || hit_set || hit_clr || hit_mr1 ||
        hit_aux || hit_txd || hit_ctl;

    // Write strobes and the input change read strobe
    wire wr_mask = wr && hit_mask;
    wire wr_set = wr && hit_set && pwdata[uic_pkg::PORT_BIT];
    wire wr_clr = wr && hit_clr && pwdata[uic_pkg::PORT_BIT];
    wire wr_txd = wr && hit_txd;
    wire rd_ipcr = rd && hit_ipcr;

    // Clear-to-send input with change filter
    uic_cts_in #(
        .FILTER_CYC(FILTER_CYC)
    ) u_cts (
        .clock(clock),
        .rst_n(rst_n),
        .cts_pin(cts_pin),
        .cts_level(cts_level),
        .cos_pulse(cos_pulse)
    );

    // Transmit holding register and its ready flag
    uic_tx_hold u_tx (
        .clock(clock),
        .rst_n(rst_n),
        .tx_enable(ctrl[uic_pkg::CTRL_TXEN_BIT]),
        .wr_stb(wr_txd),
        .wr_data(pwdata[7:0]),
        .shift_take(tx_shift_take),
        .tx_ready(tx_ready),
        .char_valid(tx_char_valid),
        .char_data(tx_char)
    );

    // Change flag: a new change wins over a clearing read
    wire next_ipcr_cos = cos_pulse || (ipcr_cos && !rd_ipcr);

    // Next interrupt flags, always shown unmasked on read
    wire rx_src = mode1[uic_pkg::MR1_RF_BIT] ? fifo_full_in
        : rx_ready_in;
    wire cos_src = next_ipcr_cos && aux[uic_pkg::AUX_IEC_BIT];
    wire [7:0] next_isr = {cos_src, 4'h0, delta_break_in, rx_src,
        tx_ready};
    wire [7:0] next_mask = wr_mask ? (pwdata[7:0] & uic_pkg::IMR_VALID)
        : mask;
    wire next_irq = |(next_isr & next_mask);

    // Output port bit: set and clear come through separate addresses
    wire next_rts = (rts_bit || wr_set) && !wr_clr;

    // Input change register image
    wire [7:0] ipcr_word = uic_pkg::IPCR_FIXED |
        (8'(ipcr_cos) << uic_pkg::IPCR_COS_BIT) |
        (8'(cts_level) << uic_pkg::IPCR_CTS_BIT);
    wire [7:0] uip_word = 8'(cts_level) << uic_pkg::IPCR_CTS_BIT;

    // Read selection; write-only locations read back as zero
    wire [7:0] rd_byte =
        hit_mask ? mask :
        hit_isr ? isr :
        hit_vec ? irq_vector :
        hit_uip ? uip_word :
        hit_ipcr ? ipcr_word :
        hit_mr1 ? mode1 :
        hit_aux ? aux :
        hit_ctl ? ctrl : 8'h00;
    wire [31:0] rd_word = {24'h00_0000, rd_byte};

    // Bus answer: one wait-free access cycle after setup
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= uic_pkg::WORD_ZERO;
        end
        else
        begin
            pready <= setup;
            pslverr <= setup && !mapped;
            // Data captured in setup, so input level is latched at the read
            prdata <= (setup && !pwrite) ? rd_word : prdata;
        end
    end

    // Software-written configuration
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            mask <= 8'h00;
            mode1 <= 8'h00;
            aux <= 8'h00;
            ctrl <= 8'h00;
            irq_vector <= uic_pkg::VECTOR_RESET;
        end
        else
        begin
            mask <= next_mask;
            mode1 <= (wr && hit_mr1) ? pwdata[7:0] : mode1;
            aux <= (wr && hit_aux) ? pwdata[7:0] : aux;
            ctrl <= (wr && hit_ctl) ? pwdata[7:0] : ctrl;
            irq_vector <= (wr && hit_vec) ? pwdata[7:0] : irq_vector;
        end
    end

    // Baud preload halves; the minimum of two is left to software
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            baud_preload <= uic_pkg::BAUD_RESET;
        else
        begin
            if (wr && hit_bhi)
                baud_preload[15:8] <= pwdata[7:0];
            if (wr && hit_blo)
                baud_preload[7:0] <= pwdata[7:0];
        end
    end

    // Flags and interrupt move on the same edge, so they never disagree
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            isr <= 8'h00;
            irq <= 1'b0;
            ipcr_cos <= 1'b0;
        end
        else
        begin
            isr <= next_isr;
            irq <= next_irq;
            ipcr_cos <= next_ipcr_cos;
        end
    end

    // Request-to-send: bit high drives the active-low pin low
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            rts_bit <= 1'b0;
            rts_n <= 1'b1;
        end
        else
        begin
            rts_bit <= next_rts;
            rts_n <= !next_rts;
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_irq_from_mask: assert property (
        irq == |(isr & mask))
        else $error("Interrupt disagrees with enabled flags");
    a_irq_same_cycle: assert property (
        $rose(irq) |-> |(isr & mask) && !$past(|(isr & mask)))
        else $error("Interrupt rose apart from its flags");
    a_rx_flag_select: assert property (
        isr[uic_pkg::ISR_RECEIVER_READY_FLAG] == $past(mode1[uic_pkg::MR1_RF_BIT] ?
        fifo_full_in : rx_ready_in))
        else $error("Receiver flag picked wrong source");
    a_tx_flag_mirror: assert property (
        isr[uic_pkg::ISR_TRANSMITTER_READY_FLAG] == $past(tx_ready))
        else $error("Transmit flag does not mirror ready");
    a_status_unmasked: assert property (
        setup && !pwrite && hit_isr |=> prdata[7:0] == $past(isr))
        else $error("Status read not true flags");
    a_mask_bits_only: assert property (
        (mask & ~uic_pkg::IMR_VALID) == 8'h00)
        else $error("Unused mask bit set");
    a_baud_write_only: assert property (
        setup && !pwrite && (hit_bhi || hit_blo) |=> prdata == 32'h0000_0000)
        else $error("Preload register readable");
    a_baud_high_byte: assert property (
        wr && hit_bhi |=> baud_preload[15:8] == $past(pwdata[7:0]))
        else $error("High preload byte not stored");
    a_vector_reset: assert property (
        $rose(rst_n) |-> irq_vector == uic_pkg::VECTOR_RESET)
        else $error("Vector not at reset value");
    a_uip_cts_level: assert property (
        setup && !pwrite && (hit_uip || hit_ipcr) |=>
        prdata[uic_pkg::IPCR_CTS_BIT] == $past(cts_level))
        else $error("Input level read wrong");
    a_rts_set_pin: assert property (
        wr_set |=> !rts_n)
        else $error("Set did not assert pin");
    a_rts_clear_pin: assert property (
        wr_clr |=> rts_n)
        else $error("Clear did not negate pin");
    a_rts_zero_keep: assert property (
        wr && (hit_set || hit_clr) && !pwdata[uic_pkg::PORT_BIT]
        |=> $stable(rts_n) && rts_n == !rts_bit)
        else $error("Zero write moved pin");
    a_cos_gated_iec: assert property (
        isr[uic_pkg::ISR_COS] == $past(next_ipcr_cos &&
        aux[uic_pkg::AUX_IEC_BIT]))
        else $error("Change flag gating wrong");

    // Masking, preload, vector and port bits seen from the register side
    a_irq_none_masked: assert property (
        mask == 8'h00 |-> !irq)
        else $error("Interrupt with every source masked");
    a_irq_any_enabled: assert property (
        |(next_isr & next_mask) |=> irq)
        else $error("Enabled flag gave no interrupt");
    a_mask_write: assert property (
        wr_mask |=> mask == ($past(pwdata[7:0]) & uic_pkg::IMR_VALID))
        else $error("Mask write not stored");
    a_baud_low_byte: assert property (
        wr && hit_blo |=> baud_preload[7:0] == $past(pwdata[7:0]))
        else $error("Low preload byte not stored");
    a_baud_hold: assert property (
        !(wr && (hit_bhi || hit_blo)) |=> $stable(baud_preload))
        else $error("Preload moved without a write");
    a_vector_write: assert property (
        wr && hit_vec |=> irq_vector == $past(pwdata[7:0]))
        else $error("Vector write not stored");
    a_vector_hold: assert property (
        !(wr && hit_vec) |=> $stable(irq_vector))
        else $error("Vector moved without a write");
    a_ipcr_fixed_ones: assert property (
        setup && !pwrite && hit_ipcr |=>
        (prdata[7:0] & uic_pkg::IPCR_FIXED) == uic_pkg::IPCR_FIXED)
        else $error("Input change fixed bits wrong");
    a_rts_hold: assert property (
        !wr_set && !wr_clr |=> $stable(rts_n))
        else $error("Pin moved without a command");
    a_rts_inverted: assert property (
        rts_n == !rts_bit)
        else $error("Pin not inverse of port bit");

    // Change flag: a read clears it, a fresh change always wins
    a_cos_read_clears: assert property (
        rd_ipcr && !cos_pulse |=> !ipcr_cos)
        else $error("Change flag survived its read");
    a_cos_set_wins: assert property (
        cos_pulse |=> ipcr_cos)
        else $error("Change lost against a read");

    // Transmit flag and dropped characters seen at the top
    a_tx_flag_disabled: assert property (
        !ctrl[uic_pkg::CTRL_TXEN_BIT] |-> ##2 !isr[uic_pkg::ISR_TRANSMITTER_READY_FLAG])
        else $error("Transmit flag set while disabled");
    a_tx_write_dropped: assert property (
        wr_txd && !tx_ready |=> $stable(tx_char))
        else $error("Character kept while not ready");

    c_irq_rise: cover property ($rose(irq));
    c_cos_irq: cover property (isr[uic_pkg::ISR_COS] && irq);
    c_rts_toggle: cover property (wr_set ##[1:20] wr_clr);
endmodule
`default_nettype wire

// file: logic/uic_pkg.sv
`default_nettype none
package uic_pkg;
    // Register byte addresses on the APB bus
    localparam logic [7:0] ADDR_MASK = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_BAUD_HI = 8'h08;
    localparam logic [7:0] ADDR_BAUD_LO = 8'h0C;
    localparam logic [7:0] ADDR_VECTOR = 8'h10;
    localparam logic [7:0] ADDR_IN_LEVEL = 8'h14;
    localparam logic [7:0] ADDR_IN_CHANGE = 8'h18;
    localparam logic [7:0] ADDR_OUT_SET = 8'h1C;
    localparam logic [7:0] ADDR_OUT_CLEAR = 8'h20;
    localparam logic [7:0] ADDR_MODE1 = 8'h24;
    localparam logic [7:0] ADDR_AUX = 8'h28;
    localparam logic [7:0] ADDR_TX_DATA = 8'h2C;
    localparam logic [7:0] ADDR_TX_CTRL = 8'h30;

    // Interrupt status and mask bit positions
    localparam int ISR_TRANSMITTER_READY_FLAG = 0;
    localparam int ISR_RECEIVER_READY_FLAG = 1;
    localparam int ISR_DB = 2;
    localparam int ISR_COS = 7;
    localparam logic [7:0] IMR_VALID = 8'h87;

    // Control field positions
    localparam int MR1_RF_BIT = 6;
    localparam int AUX_IEC_BIT = 0;
    localparam int CTRL_TXEN_BIT = 0;
    localparam int PORT_BIT = 0;
    localparam int IPCR_COS_BIT = 4;
    localparam int IPCR_CTS_BIT = 0;

    // Reset and fixed values
    localparam logic [7:0] VECTOR_RESET = 8'h0F;
    localparam logic [7:0] IPCR_FIXED = 8'h0E;
    localparam logic [15:0] BAUD_RESET = 16'h0002;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    // Change-of-state filter time and its cycle count
    localparam int CLK_PERIOD_NS = 8;
    localparam int COS_FILTER_NS = 25000;
    localparam int COS_FILTER_CYC =
        (COS_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage
`default_nettype wire

// file: logic/uic_cts_in.sv
`default_nettype none
module uic_cts_in #(
    parameter int FILTER_CYC = uic_pkg::COS_FILTER_CYC
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic cts_pin,
    output logic cts_level,
    output logic cos_pulse
);
    logic sync1;
    logic sync2;
    logic [11:0] stable_cnt;
    wire differ = sync2 != cts_level;
    wire done = stable_cnt == 12'(FILTER_CYC - 1);

    // Two stages before any logic reads the pin
    always_ff @(posedge clock)
    begin
        sync1 <= rst_n ? cts_pin : 1'b1;
        sync2 <= rst_n ? sync1 : 1'b1;
    end

    // Only a level held for the whole filter time counts as a change
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            stable_cnt <= 12'h000;
            cts_level <= 1'b1;
            cos_pulse <= 1'b0;
        end
        else
        begin
            stable_cnt <= (differ && !done) ? stable_cnt + 12'h001 : 12'h000;
            cts_level <= (differ && done) ? sync2 : cts_level;
            cos_pulse <= differ && done;
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_cos_marks_change: assert property (
        cos_pulse |-> cts_level != $past(cts_level))
        else $error("Change pulse without level change");
    c_cos_seen: cover property (cos_pulse);
endmodule
`default_nettype wire

// file: logic/uic_tx_hold.sv
`default_nettype none
module uic_tx_hold (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic tx_enable,
    input wire logic wr_stb,
    input wire logic [7:0] wr_data,
    input wire logic shift_take,
    output logic tx_ready,
    output logic char_valid,
    output logic [7:0] char_data
);
    // A write counts only while ready and enabled
    wire accept = wr_stb && tx_ready && tx_enable;
    wire taken = shift_take && char_valid;
    logic en_q;

    // Holding register and ready flag
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            en_q <= 1'b0;
            tx_ready <= 1'b0;
            char_valid <= 1'b0;
            char_data <= 8'h00;
        end
        else
        begin
            en_q <= tx_enable;
            char_data <= accept ? wr_data : char_data;
            char_valid <= accept || (char_valid && !taken);
            if (!tx_enable)
                tx_ready <= 1'b0;
            else if (accept)
                tx_ready <= 1'b0;
            else if (taken || !en_q)
                tx_ready <= 1'b1;
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_tx_discard_write: assert property (
        wr_stb && !tx_ready |=> $stable(char_data))
        else $error("Character taken while not ready");
    // A write in the same cycle is dropped while ready is low; only with ready already high does it refill the register and drop ready
    a_tx_reload_ready: assert property (
        taken && !wr_stb && tx_enable && $past(tx_enable) |=> tx_ready)
        else $error("Ready not restored after shift load");
    c_tx_discard: cover property (wr_stb && !tx_ready && tx_enable);
endmodule
`default_nettype wire

// file: testbench/uic_modem_model.sv
`default_nettype none
module uic_modem_model (
    input wire logic clock,
    input wire logic cts_cmd,
    input wire logic rts_n,
    output logic cts_pin,
    output logic rts_asserted
);
    timeunit 1ns;
    timeprecision 1ps;

    // Terminal moves its clear-to-send line on its own clock edge
    always_ff @(posedge clock)
    begin
        cts_pin <= cts_cmd;
    end

    // Request-to-send is active low on the wire
    assign rts_asserted = ~rts_n;
endmodule
`default_nettype wire

// file: testbench/uic_top_tb_top.sv
`default_nettype none
module uic_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int FC = 4;
    logic clock, rst_n, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0] paddr, irq_vector, tx_char;
    logic [31:0] pwdata, prdata, rd_q;
    logic [15:0] baud_preload;
    logic cts_pin, rts_n, rx_ready_in, fifo_full_in, delta_break_in;
    logic tx_shift_take, tx_char_valid, cts_cmd, rts_asserted, err_q;
    int fail_count = 0;
    int n_checks = 0;
    int cyc = 0;

    uic_top #(.FILTER_CYC(FC)) dut_u (
        .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cts_pin(cts_pin),
        .rts_n(rts_n), .irq(irq), .irq_vector(irq_vector),
        .baud_preload(baud_preload), .rx_ready_in(rx_ready_in),
        .fifo_full_in(fifo_full_in), .delta_break_in(delta_break_in),
        .tx_shift_take(tx_shift_take), .tx_char_valid(tx_char_valid),
        .tx_char(tx_char));

    uic_modem_model modem_u (
        .clock(clock), .cts_cmd(cts_cmd), .rts_n(rts_n),
        .cts_pin(cts_pin), .rts_asserted(rts_asserted));

    // Free running 125 MHz clock
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Cuts a hung handshake short; the run needs well under a thousand
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            fail_count++;
            close_out();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One APB transfer; holds the request until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge clock);
        penable <= 1'b1;
        // Waits as long as the slave needs; only the timeout ends it
        do
        begin
            @(posedge clock);
        end
        while (pready !== 1'b1);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e,
                      input string nm);
        apb(1'b0, a, 8'h00);
        chk(nm, {24'h00_0000, e}, rd_q);
    endtask

    // Lets registered outputs land before they are looked at
    task automatic settle();
        repeat (2) @(posedge clock);
        #1;
    endtask

    // Main sequence: software init order, then each feature in turn
    initial
    begin
        rst_n = 1'b0;
        {psel, penable, pwrite} = 3'h0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        {rx_ready_in, fifo_full_in, delta_break_in} = 3'h0;
        tx_shift_take = 1'b0;
        cts_cmd = 1'b1;
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        rd(uic_pkg::ADDR_VECTOR, 8'h0F, "vector");
        chk("irq_vec", 32'h0000_000F, {24'h00_0000, irq_vector});
        chk("rts_n", 32'h0000_0001, {31'h0, rts_n});
        wr(uic_pkg::ADDR_VECTOR, 8'h40);
        settle();
        chk("irq_vec", 32'h0000_0040, {24'h00_0000, irq_vector});
        wr(uic_pkg::ADDR_MASK, 8'h87);
        rd(uic_pkg::ADDR_MASK, 8'h87, "mask");
        wr(uic_pkg::ADDR_AUX, 8'h01);
        // Preload of 0x1234 stays above the floor of two
        wr(uic_pkg::ADDR_BAUD_HI, 8'h12);
        wr(uic_pkg::ADDR_BAUD_LO, 8'h34);
        settle();
        chk("baud", 32'h0000_1234, {16'h0000, baud_preload});
        rd(uic_pkg::ADDR_BAUD_HI, 8'h00, "baud_hi");
        rd(uic_pkg::ADDR_BAUD_LO, 8'h00, "baud_lo");
        wr(uic_pkg::ADDR_MODE1, 8'h00);
        wr(uic_pkg::ADDR_TX_CTRL, 8'h01);
        // Ready needs a cycle, the status register one more
        settle();
        rd(uic_pkg::ADDR_STATUS, 8'h01, "status");
        chk("irq", 32'h0000_0001, {31'h0, irq});
        // Second character while full must be dropped
        wr(uic_pkg::ADDR_TX_DATA, 8'hA5);
        wr(uic_pkg::ADDR_TX_DATA, 8'h5A);
        settle();
        chk("tx_valid", 32'h0000_0001, {31'h0, tx_char_valid});
        chk("tx_char", 32'h0000_00A5, {24'h00_0000, tx_char});
        rd(uic_pkg::ADDR_STATUS, 8'h00, "status");
        chk("irq", 32'h0000_0000, {31'h0, irq});
        tx_shift_take <= 1'b1;
        @(posedge clock);
        tx_shift_take <= 1'b0;
        rd(uic_pkg::ADDR_STATUS, 8'h01, "status");
        chk("tx_valid", 32'h0000_0000, {31'h0, tx_char_valid});
        // Receiver flag source follows the mode bit
        rx_ready_in <= 1'b1;
        rd(uic_pkg::ADDR_STATUS, 8'h03, "status");
        wr(uic_pkg::ADDR_MODE1, 8'h40);
        rd(uic_pkg::ADDR_STATUS, 8'h01, "status");
        fifo_full_in <= 1'b1;
        rd(uic_pkg::ADDR_STATUS, 8'h03, "status");
        wr(uic_pkg::ADDR_MASK, 8'h00);
        settle();
        chk("irq", 32'h0000_0000, {31'h0, irq});
        rd(uic_pkg::ADDR_STATUS, 8'h03, "status");
        wr(uic_pkg::ADDR_MASK, 8'h02);
        settle();
        chk("irq", 32'h0000_0001, {31'h0, irq});
        delta_break_in <= 1'b1;
        fifo_full_in <= 1'b0;
        wr(uic_pkg::ADDR_MASK, 8'h04);
        rd(uic_pkg::ADDR_STATUS, 8'h05, "status");
        chk("irq", 32'h0000_0001, {31'h0, irq});
        delta_break_in <= 1'b0;
        wr(uic_pkg::ADDR_TX_CTRL, 8'h00);
        settle();
        rd(uic_pkg::ADDR_STATUS, 8'h00, "status");
        // Clear-to-send falls; filter and sync need FC plus three
        wr(uic_pkg::ADDR_MASK, 8'h80);
        cts_cmd <= 1'b0;
        repeat (FC + 12) @(posedge clock);
        rd(uic_pkg::ADDR_IN_LEVEL, 8'h00, "in_level");
        rd(uic_pkg::ADDR_STATUS, 8'h80, "status");
        chk("irq", 32'h0000_0001, {31'h0, irq});
        rd(uic_pkg::ADDR_IN_CHANGE, 8'h1E, "in_change");
        rd(uic_pkg::ADDR_STATUS, 8'h00, "status");
        cts_cmd <= 1'b1;
        repeat (FC + 12) @(posedge clock);
        rd(uic_pkg::ADDR_IN_LEVEL, 8'h01, "in_level");
        rd(uic_pkg::ADDR_IN_CHANGE, 8'h1F, "in_change");
        // With input enable off a change stays out of the status
        wr(uic_pkg::ADDR_AUX, 8'h00);
        cts_cmd <= 1'b0;
        repeat (FC + 12) @(posedge clock);
        rd(uic_pkg::ADDR_STATUS, 8'h00, "status");
        chk("irq", 32'h0000_0000, {31'h0, irq});
        rd(uic_pkg::ADDR_IN_CHANGE, 8'h1E, "in_change");
        // Set and clear addresses ignore a zero in bit 0
        wr(uic_pkg::ADDR_OUT_SET, 8'h00);
        settle();
        chk("rts_n", 32'h0000_0001, {31'h0, rts_n});
        wr(uic_pkg::ADDR_OUT_SET, 8'h01);
        settle();
        chk("rts_n", 32'h0000_0000, {31'h0, rts_n});
        chk("rts_seen", 32'h0000_0001, {31'h0, rts_asserted});
        wr(uic_pkg::ADDR_OUT_CLEAR, 8'h00);
        settle();
        chk("rts_n", 32'h0000_0000, {31'h0, rts_n});
        wr(uic_pkg::ADDR_OUT_CLEAR, 8'h01);
        settle();
        chk("rts_n", 32'h0000_0001, {31'h0, rts_n});
        // Unmapped address is refused and reads zero
        rd(8'hFC, 8'h00, "unmapped");
        chk("slverr", 32'h0000_0001, {31'h0, err_q});
        close_out();
    end
endmodule
`default_nettype wire
